// ==== lcp_channel_port.sv ====
// host channel front end: address decode, strobes, replies, select/line control/trap registers
// ----------------------------------------
// Behaviour
// - two select codes: controller, enabled link unit
// - odd select parity fail: no action, no reply
// - five one-hot strobes decoded
// - command word on lines 1-15, addressed only
// - line 0 ignored during command
// - write strobe accepts the word
// - read strobe drives read data
// - status on 6-15, code plus parity 0-5
// - status answered even while busy
// - poll drives own interrupt bit
// - reply only after decode, settle; unit cp/dp/dr also wait for the transfer
// - reply drops after all strobes low
// - busy flag raised together with reply
// - fault by reply, held while addressed
// - sticky interrupt lead, cleared by command
// - low six select bits unused
// - controller command overwrites select register
// - line control written after select points
// - matched dual decoders drive 16 enables
// - command field: fixed, programmable, length bits
// - trap errors, status returns select code
// ----------------------------------------
`timescale 1ns/1ps
module lcp_channel_port #(
  parameter logic [4:0] CTRL_CODE = 5'h0a, // arbitrary select code
  parameter logic [4:0] UNIT_CODE = 5'h0b, // arbitrary select code
  parameter int POLL_BIT = 3
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [5:0] adr_pins,
  input wire lcp_pkg::lcp_strobe_s strobe_pins,
  input wire logic [15:0] word_in,
  output logic [15:0] word_out,
  output logic word_oe_n,
  output logic sync_reply,
  output logic busy_reply,
  output logic fault_reply,
  output logic intr_reply,
  output logic [15:0] unit_enable,
  output logic [11:0] link_command,
  output logic unit_req,
  output logic [1:0] unit_op,
  output logic [15:0] unit_wdata,
  input wire logic [15:0] unit_rdata,
  input wire logic unit_done,
  input wire logic unit_fault,
  input wire logic unit_busy,
  input wire logic [15:0] unit_intr,
  output logic [2:0] micro_bank,
  output logic maint_test
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // parity bit that makes a five-bit code plus itself odd
  function automatic logic odd_par(input logic [4:0] c);
    odd_par = ~(^c);
  endfunction
  // second enable decoder, built differently from the shift form
  function automatic logic [15:0] dec_loop(input logic [3:0] a);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = (a == 4'(i));
    end
    dec_loop = r;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] adr_s1, adr_s2;
  lcp_pkg::lcp_strobe_s stb_s1, stb_s2;
  logic [15:0] word_s1, word_s2, uint_s1, uint_s2;
  // two flops on every pin from the host or the unit interrupt pairs
  always_ff @(posedge mclk) begin
    if (clk_en) begin
      adr_s1 <= adr_pins;
      adr_s2 <= adr_s1;
      stb_s1 <= strobe_pins;
      stb_s2 <= stb_s1;
      word_s1 <= word_in;
      word_s2 <= word_s1;
      uint_s1 <= unit_intr;
      uint_s2 <= uint_s1;
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  lcp_pkg::lcp_state_e state_reg, state_next;
  logic [15:0] sel_reg, sel_next, lcr_reg, lcr_next, intr_reg, intr_next;
  logic [9:0] trap_reg, trap_next, trap_set;
  logic [15:0] rd_word, out_reg, out_next, dec_a, dec_b;
  logic [1:0] uop_reg, uop_next;
  logic [1:0] sel_idx;
  logic [4:0] my_code;
  logic par_ok, hit_ctrl, hit_unit, hit, stb_any, stb_one, stb_none;
  logic act, ctrl_act, unit_act, drive_reg, drive_next, busy_cap_reg;
  logic dec_mis, clr_trap, clr_intr, in_settle;
  logic [14:0] word_hi;
  lcp_pkg::lcp_lcr_s lcr_f;
  // select code check: odd parity over all six lines, then one of two codes
  assign par_ok = ^adr_s2;
  assign hit_ctrl = par_ok && (adr_s2[4:0] == CTRL_CODE);
  assign hit_unit = par_ok && (adr_s2[4:0] == UNIT_CODE);
  assign hit = hit_ctrl || hit_unit;
  // strobes must be one-hot; anything else is not understood
  assign stb_any = |stb_s2;
  assign stb_none = !stb_any;
  assign stb_one = $onehot(stb_s2);
  assign act = (state_reg == lcp_pkg::ST_DECODE) && stb_one && hit;
  assign ctrl_act = act && hit_ctrl;
  assign unit_act = act && hit_unit && (stb_s2.cp || stb_s2.dp || stb_s2.dr);
  assign in_settle = (state_reg == lcp_pkg::ST_SETTLE);
  assign word_hi = word_s2[15:1];
  assign my_code = hit_unit ? UNIT_CODE : CTRL_CODE;
  // low six select bits form the sequence code field and steer nothing here
  assign sel_idx = sel_reg[lcp_pkg::SEL_IDX_HI:lcp_pkg::SEL_IDX_LO];
  assign clr_trap = ctrl_act && stb_s2.cp && word_s2[lcp_pkg::SEL_CLR_TRAP];
  assign clr_intr = ctrl_act && stb_s2.cp && word_s2[lcp_pkg::SEL_CLR_INTR];

  // ----------------------------------------
  // registers written by the host
  // ----------------------------------------
  // a controller command replaces the select word; line 0 is the channel's own bit
  assign sel_next = (ctrl_act && stb_s2.cp) ? {word_hi, 1'b0} : sel_reg;
  // line control only takes a write once the select register points at it
  assign lcr_next = (ctrl_act && stb_s2.dp && sel_idx == lcp_pkg::IDX_LCR) ? word_s2 : lcr_reg;
  // set beats clear so a request arriving with the clear is kept
  assign intr_next = (clr_intr ? 16'h0000 : intr_reg) | uint_s2;
  assign lcr_f = lcr_reg;

  // ----------------------------------------
  // enable decoders and error trap
  // ----------------------------------------
  // two decoders compared; on disagreement no unit is enabled at all
  assign dec_a = 16'h0001 << lcr_f.enable;
  assign dec_b = dec_loop(lcr_f.enable);
  assign dec_mis = (dec_a != dec_b);
  // every error source lands in the trap; new errors win over a clear
  always_comb begin
    trap_set = 10'h000;
    trap_set[lcp_pkg::TRAP_DEC] = dec_mis;
    trap_set[lcp_pkg::TRAP_UFAULT] = (state_reg == lcp_pkg::ST_WAIT) && unit_done && unit_fault;
    trap_set[lcp_pkg::TRAP_ABORT] = (state_reg == lcp_pkg::ST_WAIT) && !unit_done && stb_none;
    trap_set[lcp_pkg::TRAP_STIM] = act && sel_reg[lcp_pkg::SEL_STIM];
    trap_set[lcp_pkg::TRAP_MULTI] = (state_reg == lcp_pkg::ST_IDLE) && hit && stb_any && !stb_one;
  end
  assign trap_next = (clr_trap ? 10'h000 : trap_reg) | trap_set;

  // ----------------------------------------
  // read selection
  // ----------------------------------------
  // status carries the trap above the returned select code and its parity
  always_comb begin
    rd_word = 16'h0000;
    if (stb_s2.status_sense_strobe) begin
      rd_word = {trap_reg, odd_par(my_code), my_code};
    end else if (stb_s2.interrupt_poll_strobe) begin
      rd_word[POLL_BIT] = |intr_reg;
    end else begin
      case (sel_idx)
        lcp_pkg::IDX_LCR: rd_word = lcr_reg;
        lcp_pkg::IDX_TRAP: rd_word = {6'h00, trap_reg};
        lcp_pkg::IDX_INTR: rd_word = intr_reg;
        lcp_pkg::IDX_SEL: rd_word = sel_reg;
        default: rd_word = 16'h0000;
      endcase
    end
  end
  // unit reads are captured on completion, controller reads at decode
  assign out_next = (act && !unit_act) ? rd_word :
                    ((state_reg == lcp_pkg::ST_WAIT) && unit_done && uop_reg == lcp_pkg::UOP_RD) ?
                    unit_rdata : out_reg;
  assign drive_next = act ? (stb_s2.dr || stb_s2.status_sense_strobe || stb_s2.interrupt_poll_strobe) : drive_reg;
  assign uop_next = stb_s2.dp ? lcp_pkg::UOP_WR : (stb_s2.dr ? lcp_pkg::UOP_RD : lcp_pkg::UOP_CMD);

  // ----------------------------------------
  // handshake sequencer
  // ----------------------------------------
  // the host keeps strobe and data still until the reply, so decode waits one
  // cycle after the strobe is seen to let the data lines settle through the flops
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lcp_pkg::ST_IDLE: begin
        if (stb_one && hit) begin
          state_next = lcp_pkg::ST_DECODE;
        end
      end
      lcp_pkg::ST_DECODE: begin
        if (!act) begin
          state_next = lcp_pkg::ST_IDLE;
        end else if (unit_act) begin
          state_next = lcp_pkg::ST_WAIT;
        end else begin
          state_next = lcp_pkg::ST_SETTLE;
        end
      end
      lcp_pkg::ST_WAIT: begin
        if (unit_done) begin
          state_next = lcp_pkg::ST_SETTLE;
        end else if (stb_none) begin
          state_next = lcp_pkg::ST_IDLE; // host gave up: drop the transfer
        end
      end
      lcp_pkg::ST_SETTLE: state_next = lcp_pkg::ST_REPLY;
      lcp_pkg::ST_REPLY: begin
        if (stb_none) begin
          state_next = lcp_pkg::ST_IDLE;
        end
      end
      default: state_next = lcp_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  // sequencer and host visible registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= lcp_pkg::ST_IDLE;
      sel_reg <= lcp_pkg::SEL_RST;
      lcr_reg <= lcp_pkg::LCR_RST;
      intr_reg <= 16'h0000;
      trap_reg <= 10'h000;
      out_reg <= 16'h0000;
      drive_reg <= 1'b0;
      uop_reg <= lcp_pkg::UOP_CMD;
    end else if (clk_en) begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      lcr_reg <= lcr_next;
      intr_reg <= intr_next;
      trap_reg <= trap_next;
      out_reg <= out_next;
      drive_reg <= drive_next;
      uop_reg <= act ? uop_next : uop_reg;
    end
  end
  // replies to the host; busy and sync come from the same decision
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      word_out <= 16'h0000;
      word_oe_n <= 1'b1;
      sync_reply <= 1'b0;
      busy_reply <= 1'b0;
      fault_reply <= 1'b0;
      intr_reply <= 1'b0;
      busy_cap_reg <= 1'b0;
    end else if (clk_en) begin
      word_out <= out_next;
      word_oe_n <= !(drive_next && (state_next == lcp_pkg::ST_SETTLE || state_next == lcp_pkg::ST_REPLY));
      sync_reply <= (state_next == lcp_pkg::ST_REPLY);
      busy_reply <= (state_next == lcp_pkg::ST_REPLY) && busy_cap_reg;
      busy_cap_reg <= act ? 1'b0 : (((state_reg == lcp_pkg::ST_WAIT) && unit_done) ? unit_busy : busy_cap_reg);
      fault_reply <= hit && (|trap_next);
      intr_reply <= |intr_next;
    end
  end
  // link unit side: enable pairs, command field and transfer request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      unit_enable <= 16'h0000;
      link_command <= 12'h000;
      unit_req <= 1'b0;
      unit_op <= lcp_pkg::UOP_CMD;
      unit_wdata <= 16'h0000;
      micro_bank <= 3'h0;
      maint_test <= 1'b0;
    end else if (clk_en) begin
      unit_enable <= dec_mis ? 16'h0000 : dec_a;
      link_command <= {lcr_f.blk, lcr_f.prog, lcr_f.fixed};
      unit_req <= unit_act;
      unit_op <= unit_act ? uop_next : unit_op;
      unit_wdata <= unit_act ? {word_hi, stb_s2.cp ? 1'b0 : word_s2[0]} : unit_wdata;
      micro_bank <= sel_reg[lcp_pkg::SEL_BANK_HI:lcp_pkg::SEL_BANK_LO];
      maint_test <= sel_reg[lcp_pkg::SEL_MAINT];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk iff clk_en); endclocking
  default disable iff (!rst_n);
  code_decode_a: assert property ((state_reg == lcp_pkg::ST_IDLE) && stb_any && !hit |=> state_reg == lcp_pkg::ST_IDLE) else $error("acted on a foreign select code");
  parity_block_a: assert property (!par_ok |=> !unit_req && !$rose(sync_reply)) else $error("action on bad parity");
  strobe_onehot_a: assert property ((state_reg == lcp_pkg::ST_IDLE) && !stb_one |=> state_reg == lcp_pkg::ST_IDLE) else $error("non one-hot strobe taken");
  sel_load_a: assert property (ctrl_act && stb_s2.cp |=> sel_reg[15:1] == $past(word_hi) && !sel_reg[0]) else $error("select register not overwritten");
  lcr_load_a: assert property (ctrl_act && stb_s2.dp && sel_idx == lcp_pkg::IDX_LCR |=> lcr_reg == $past(word_s2)) else $error("line control not written");
  status_code_a: assert property (sync_reply && !word_oe_n && (uop_reg == lcp_pkg::UOP_CMD) && $past(stb_s2.status_sense_strobe, 3) |-> ^word_out[5:0]) else $error("status code parity wrong");
  sst_answer_a: assert property (act && stb_s2.status_sense_strobe |-> ##2 sync_reply && !word_oe_n) else $error("status not answered in two cycles");
  sync_after_a: assert property ($rose(sync_reply) |-> $past(in_settle)) else $error("reply without settle");
  sync_release_a: assert property ($fell(sync_reply) |-> $past(stb_none)) else $error("reply dropped with strobe high");
  busy_with_a: assert property (busy_reply |-> sync_reply) else $error("busy without reply");
  fault_by_a: assert property ($rose(sync_reply) && $past(hit) && (|trap_reg) |-> fault_reply) else $error("fault later than reply");
  intr_hold_a: assert property ((|uint_s2) |=> intr_reply) else $error("interrupt request lost");
  enable_one_a: assert property ($onehot0(unit_enable)) else $error("more than one unit enabled");
  ctrl_cmd_c: cover property (ctrl_act && stb_s2.cp ##[1:4] sync_reply);
  unit_read_c: cover property (unit_act && stb_s2.dr ##[1:40] sync_reply && !word_oe_n);
  status_c: cover property (act && stb_s2.status_sense_strobe ##2 sync_reply);
  abort_c: cover property ((state_reg == lcp_pkg::ST_WAIT) && stb_none && !unit_done);
endmodule // lcp_channel_port

// ==== lcp_pkg.sv ====
// shared constants and types for the channel front end of the link controller
package lcp_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int UNITS = 16;
  localparam int TRAP_W = 10;
  // select register fields
  localparam int SEL_IDX_LO = 6;
  localparam int SEL_IDX_HI = 7;
  localparam int SEL_STIM = 8;
  localparam int SEL_BANK_LO = 9;
  localparam int SEL_BANK_HI = 11;
  localparam int SEL_MAINT = 12;
  localparam int SEL_CLR_TRAP = 13;
  localparam int SEL_CLR_INTR = 14;
  // internal register index held in the select register
  localparam logic [1:0] IDX_LCR = 2'h0;
  localparam logic [1:0] IDX_TRAP = 2'h1;
  localparam logic [1:0] IDX_INTR = 2'h2;
  localparam logic [1:0] IDX_SEL = 2'h3;
  // status trap bit positions
  localparam int TRAP_DEC = 0;
  localparam int TRAP_UFAULT = 1;
  localparam int TRAP_ABORT = 2;
  localparam int TRAP_STIM = 3;
  localparam int TRAP_MULTI = 4;
  // link unit operations
  localparam logic [1:0] UOP_CMD = 2'h0;
  localparam logic [1:0] UOP_WR = 2'h1;
  localparam logic [1:0] UOP_RD = 2'h2;
  // reset values
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [15:0] LCR_RST = 16'h0000;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic cp;
    logic dp;
    logic dr;
    logic status_sense_strobe;
    logic interrupt_poll_strobe;
  } lcp_strobe_s;
  typedef struct packed {
    logic blk;
    logic [6:0] prog;
    logic [3:0] fixed;
    logic [3:0] enable;
  } lcp_lcr_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECODE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SETTLE = 3'b011,
    ST_REPLY = 3'b100
  } lcp_state_e;
endpackage

// ==== lcp_unit_model.sv ====
// behavioural link unit standing behind the channel port
`timescale 1ns/1ps
module lcp_unit_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic unit_req,
  input wire logic [1:0] unit_op,
  input wire logic [15:0] unit_wdata,
  input wire logic [3:0] delay,
  input wire logic inject_fault,
  input wire logic busy_mode,
  output logic [15:0] unit_rdata,
  output logic unit_done,
  output logic unit_fault,
  output logic unit_busy
);
  logic [15:0] store_reg;
  logic [3:0] cnt_reg;
  logic pend_reg;
  // answer after a programmed wait; data toggles when not answering so stale values never match
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      cnt_reg <= 4'h0;
      store_reg <= 16'h0000;
      unit_done <= 1'b0;
      unit_fault <= 1'b0;
      unit_busy <= 1'b0;
      unit_rdata <= 16'h0000;
    end else if (unit_req) begin
      pend_reg <= 1'b1;
      cnt_reg <= delay;
      unit_done <= 1'b0;
      if (unit_op == lcp_pkg::UOP_WR) begin
        store_reg <= unit_wdata;
      end
    end else if (pend_reg && cnt_reg == 4'h0) begin
      pend_reg <= 1'b0;
      unit_done <= 1'b1;
      unit_rdata <= store_reg;
      unit_fault <= inject_fault;
      unit_busy <= busy_mode;
    end else begin
      if (pend_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
      unit_done <= 1'b0;
      unit_fault <= 1'b0;
      unit_busy <= 1'b0;
      unit_rdata <= ~unit_rdata;
    end
  end
endmodule // lcp_unit_model

// ==== link_controller_channel_port_tb.sv ====
// self-checking bench for the host channel front end
`timescale 1ns/1ps
module link_controller_channel_port_tb;
  logic mclk, rst_n, unit_req, unit_done, unit_fault, unit_busy, word_oe_n;
  logic sync_reply, busy_reply, fault_reply, intr_reply, maint_test, inj, bmode;
  logic [5:0] adr_pins;
  lcp_pkg::lcp_strobe_s strobe_pins;
  logic [15:0] word_in, word_out, unit_enable, unit_wdata, unit_rdata, unit_intr, rd;
  logic [11:0] link_command;
  logic [1:0] unit_op;
  logic [2:0] micro_bank;
  logic [3:0] dly;
  logic got_sync, got_busy, got_fault, got_oe_n;
  int err_count, compares;
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  lcp_channel_port DUT (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .adr_pins(adr_pins),
    .strobe_pins(strobe_pins), .word_in(word_in), .word_out(word_out), .word_oe_n(word_oe_n),
    .sync_reply(sync_reply), .busy_reply(busy_reply), .fault_reply(fault_reply),
    .intr_reply(intr_reply), .unit_enable(unit_enable), .link_command(link_command),
    .unit_req(unit_req), .unit_op(unit_op), .unit_wdata(unit_wdata), .unit_rdata(unit_rdata),
    .unit_done(unit_done), .unit_fault(unit_fault), .unit_busy(unit_busy),
    .unit_intr(unit_intr), .micro_bank(micro_bank), .maint_test(maint_test));
  lcp_unit_model unit (.mclk(mclk), .rst_n(rst_n), .unit_req(unit_req), .unit_op(unit_op),
    .unit_wdata(unit_wdata), .delay(dly), .inject_fault(inj), .busy_mode(bmode),
    .unit_rdata(unit_rdata), .unit_done(unit_done), .unit_fault(unit_fault), .unit_busy(unit_busy));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [5:0] adr6(input logic [4:0] c);
    return {~^c, c};
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // host transfer: strobe and word held until the reply or for 40 cycles, then released
  task automatic host_op(input logic [4:0] code, input logic [4:0] stb, input logic [15:0] w,
                         input logic badpar);
    got_sync = 1'b0;
    adr_pins = adr6(code) ^ {badpar, 5'h00};
    strobe_pins = stb;
    word_in = w;
    for (int i = 0; i < 40 && !got_sync; i++) begin
      @(posedge mclk);
      #1;
      got_sync = sync_reply;
    end
    rd = word_out;
    got_busy = busy_reply;
    got_fault = fault_reply;
    got_oe_n = word_oe_n;
    strobe_pins = 5'h00;
    word_in = 16'h0000;
    for (int i = 0; i < 10 && sync_reply !== 1'b0; i++) @(posedge mclk);
    repeat (3) @(posedge mclk);
    #1;
    chk("reply released", {15'h0, sync_reply}, 16'h0000);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_select();
    host_op(5'h0a, 5'h10, 16'h1a01, 1'b0);
    chk("cp reply", {15'h0, got_sync}, 16'h0001);
    chk("bank", {13'h0, micro_bank}, 16'h0005);
    chk("maint", {15'h0, maint_test}, 16'h0001);
    host_op(5'h0a, 5'h08, 16'hffa5, 1'b0);
    chk("enable", unit_enable, 16'h0020);
    chk("command", {4'h0, link_command}, 16'h0ffa);
    host_op(5'h0a, 5'h10, 16'h00c1, 1'b0);
    host_op(5'h0a, 5'h04, 16'h0000, 1'b0);
    chk("select read", rd, 16'h00c0);
    chk("drive", {15'h0, got_oe_n}, 16'h0000);
    host_op(5'h0a, 5'h02, 16'h0000, 1'b0);
    chk("status", rd, {10'h000, adr6(5'h0a)});
  endtask
  task automatic t_refuse();
    host_op(5'h0a, 5'h10, 16'h1a00, 1'b1);
    chk("bad parity", {15'h0, got_sync}, 16'h0000);
    host_op(5'h0c, 5'h04, 16'h0000, 1'b0);
    chk("foreign", {15'h0, got_sync}, 16'h0000);
    chk("bank kept", {13'h0, micro_bank}, 16'h0000);
  endtask
  task automatic t_unit();
    dly = 4'h0;
    host_op(5'h0b, 5'h08, 16'h1234, 1'b0);
    chk("unit write", {15'h0, got_sync}, 16'h0001);
    dly = 4'h9;
    bmode = 1'b1;
    host_op(5'h0b, 5'h04, 16'h0000, 1'b0);
    chk("unit read", rd, 16'h1234);
    chk("busy", {15'h0, got_busy}, 16'h0001);
    host_op(5'h0b, 5'h02, 16'h0000, 1'b0);
    chk("status busy", rd, {10'h000, adr6(5'h0b)});
    bmode = 1'b0;
    inj = 1'b1;
    host_op(5'h0b, 5'h10, 16'h0000, 1'b0);
    inj = 1'b0;
    chk("fault", {15'h0, got_fault}, 16'h0001);
    host_op(5'h0a, 5'h02, 16'h0000, 1'b0);
    chk("trap", rd, {10'h002, adr6(5'h0a)});
    host_op(5'h0a, 5'h10, 16'h2000, 1'b0);
    host_op(5'h0a, 5'h10, 16'h0000, 1'b0);
    host_op(5'h0a, 5'h02, 16'h0000, 1'b0);
    chk("trap clear", rd, {10'h000, adr6(5'h0a)});
    chk("no fault", {15'h0, got_fault}, 16'h0000);
  endtask
  task automatic t_intr();
    unit_intr = 16'h0004;
    repeat (5) @(posedge mclk);
    #1 unit_intr = 16'h0000;
    repeat (5) @(posedge mclk);
    #1;
    chk("intr sticky", {15'h0, intr_reply}, 16'h0001);
    host_op(5'h0a, 5'h01, 16'h0000, 1'b0);
    chk("poll bit", {15'h0, rd[3]}, 16'h0001);
    host_op(5'h0a, 5'h10, 16'h4000, 1'b0);
    host_op(5'h0a, 5'h10, 16'h0000, 1'b0);
    chk("intr clear", {15'h0, intr_reply}, 16'h0000);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    err_count = 0;
    compares = 0;
    rst_n = 1'b0;
    adr_pins = 6'h00;
    strobe_pins = 5'h00;
    word_in = 16'h0000;
    unit_intr = 16'h0000;
    dly = 4'h0;
    inj = 1'b0;
    bmode = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("reset enable", unit_enable, 16'h0001);
    chk("reset oe", {15'h0, word_oe_n}, 16'h0001);
    t_select();
    t_refuse();
    t_unit();
    t_intr();
    results();
  end
  // limit far beyond the few hundred cycles the scenarios need
  initial begin
    #400000;
    err_count++;
    results();
  end
endmodule // link_controller_channel_port_tb
